// [core/spa_stage.sv]
// The address map and the APB register port were left to the implementer.
`timescale 1ns/1ps

module spa_stage (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [spa_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // frame from preceding stage
    input wire logic frame_in_valid,
    input wire spa_pkg::spa_frame_in_t frame_in,
    // frame to following stage
    output logic frame_out_valid,
    output spa_pkg::spa_frame_out_t frame_out
);

    // ******************************************************
    // state
    // ******************************************************
    typedef struct packed {
        logic [spa_pkg::NUM_GROUPS-1:0] group_path_state;
        logic [31:0] frame_count;
        logic [31:0] discard_count;
        logic [31:0] rdata;
        logic slverr;
        logic out_valid;
        spa_pkg::spa_frame_out_t out;
    } spa_state_t;

    spa_state_t state_ff;
    spa_state_t nxt_state;

    // per-service tables; kept outside the struct as memories
    logic [1:0] prot_scheme_ff [spa_pkg::NUM_SERVICES];
    logic [spa_pkg::GRP_W-1:0] prot_group_ff [spa_pkg::NUM_SERVICES];
    logic [spa_pkg::SVC_W-1:0] prot_pidx_ff [spa_pkg::NUM_SERVICES];
    logic svc_force_ff [spa_pkg::NUM_SERVICES];
    logic [spa_pkg::NUM_PORTS-1:0] svc_mask_ff [spa_pkg::NUM_SERVICES];

    // ******************************************************
    // address decode
    // ******************************************************
    // table select: 1 protection, 2 service, 0 scalar, 3 unmapped
    function automatic logic [1:0] spa_tbl_sel(input logic [spa_pkg::ADDR_W-1:0] a);
        logic [1:0] s;
        logic [1:0] w;
        w = a[spa_pkg::TBL_SEL_LSB +: 2];
        s = spa_pkg::TBL_SEL_REG;
        if (w == spa_pkg::ADDR_PROT_BASE[spa_pkg::TBL_SEL_LSB +: 2]) begin
            s = spa_pkg::TBL_SEL_PROT;
        end else if (w == spa_pkg::ADDR_SVC_BASE[spa_pkg::TBL_SEL_LSB +: 2]) begin
            s = spa_pkg::TBL_SEL_SVC;
        end else if (w != spa_pkg::TBL_SEL_REG) begin
            s = spa_pkg::TBL_SEL_NONE;
        end
        return s;
    endfunction : spa_tbl_sel

    function automatic logic [spa_pkg::SVC_W-1:0] spa_tbl_idx(
        input logic [spa_pkg::ADDR_W-1:0] a
    );
        return a[spa_pkg::TBL_IDX_LSB +: spa_pkg::SVC_W];
    endfunction : spa_tbl_idx

    // scalar read as {error, data}; unmapped words answer with an error
    function automatic logic [32:0] spa_scalar_rd(
        input logic [spa_pkg::ADDR_W-1:0] a,
        input spa_state_t s
    );
        logic [32:0] r;
        r = {1'b1, 32'h0000_0000};
        case (a)
            spa_pkg::ADDR_GROUP_PATH_STATE: begin
                r = {1'b0, 32'(s.group_path_state)};
            end
            spa_pkg::ADDR_FRAME_COUNT: begin
                r = {1'b0, s.frame_count};
            end
            spa_pkg::ADDR_DISCARD_COUNT: begin
                r = {1'b0, s.discard_count};
            end
            default: begin
                r = {1'b1, 32'h0000_0000};
            end
        endcase
        return r;
    endfunction : spa_scalar_rd

    // groups past the last one have no state bit and read as working
    function automatic logic spa_on_protect(
        input logic [spa_pkg::NUM_GROUPS-1:0] path,
        input logic [spa_pkg::GRP_W-1:0] g
    );
        logic r;
        r = 1'b0;
        if (g < spa_pkg::GRP_W'(spa_pkg::NUM_GROUPS)) begin
            r = path[g];
        end
        return r;
    endfunction : spa_on_protect

    logic setup_phase;
    logic wr_access;
    logic [1:0] sel;
    logic [spa_pkg::SVC_W-1:0] tidx;

    assign setup_phase = psel && !penable;
    assign wr_access = psel && penable && pwrite;
    assign sel = spa_tbl_sel(paddr);
    assign tidx = spa_tbl_idx(paddr);

    // ******************************************************
    // step 1: path protection
    // ******************************************************
    logic [1:0] scheme;
    logic [spa_pkg::GRP_W-1:0] grp;
    logic on_protect;
    logic [spa_pkg::SVC_W-1:0] p_idx;
    logic p_kill;

    always_comb begin
        scheme = prot_scheme_ff[frame_in.service_index];
        grp = prot_group_ff[frame_in.service_index];
        // shared group bit: flipping it moves every service mapped to it whose scheme is not PROT_NONE
        on_protect = spa_on_protect(state_ff.group_path_state, grp);
        p_idx = frame_in.service_index;
        p_kill = 1'b0;
        case (scheme)
            spa_pkg::PROT_UPSTREAM: begin
                if (on_protect) begin
                    p_idx = prot_pidx_ff[frame_in.service_index];
                end
            end
            spa_pkg::PROT_DOWN_WORKING: begin
                p_kill = on_protect;
            end
            spa_pkg::PROT_DOWN_PROTECT: begin
                p_kill = !on_protect;
            end
            default: begin
                p_kill = 1'b0;
            end
        endcase
    end

    // ******************************************************
    // step 2: service forwarding (uses replaced index)
    // ******************************************************
    logic [spa_pkg::NUM_PORTS-1:0] s_mask;
    logic s_force;
    logic [spa_pkg::NUM_PORTS-1:0] filt_mask;
    logic [spa_pkg::NUM_PORTS-1:0] s_destination_set;

    always_comb begin
        s_mask = svc_mask_ff[p_idx];
        s_force = svc_force_ff[p_idx];
        filt_mask = frame_in.src_port_mask & frame_in.aggr_mask;
        if (p_kill) begin
            s_destination_set = '0;
        end else if (s_force) begin
            s_destination_set = s_mask & filt_mask;
        end else begin
            s_destination_set = frame_in.destination_set & s_mask;
        end
    end

    // ******************************************************
    // policy destination
    // ******************************************************
    logic [spa_pkg::NUM_PORTS-1:0] pol_destination_set;

    // policy redoes only the address step; later masks still apply
    always_comb begin
        pol_destination_set = frame_in.action.port_mask & frame_in.vlan_mask & filt_mask;
        if (!s_force) begin
            pol_destination_set = pol_destination_set & s_mask;
        end else begin
            pol_destination_set = s_mask & filt_mask;
        end
        if (p_kill) begin
            pol_destination_set = '0;
        end
    end

    // ******************************************************
    // step 3: action handling, top to bottom
    // ******************************************************
    spa_pkg::spa_frame_out_t a_out;
    logic [spa_pkg::CPU_QUEUE_MASK_W-1:0] qbit;
    logic copy_hit;
    logic once_hit;
    logic pol_first;
    logic excl_first;

    // policer fields act only on the first lookup
    assign copy_hit = frame_in.action.cpu_copy_flag;
    assign once_hit = frame_in.action.hit_once_flag && (frame_in.action.rule_hit_counter == '0);
    assign pol_first = frame_in.first_lookup && frame_in.action.policer_select_flag;
    assign excl_first = frame_in.first_lookup && frame_in.action.exclusive_rule_policing;

    always_comb begin
        a_out = '0;
        a_out.service_index = p_idx;
        a_out.destination_set = s_destination_set;
        a_out.cpu_queue_mask = frame_in.cpu_queue_mask;
        a_out.learn_disable = frame_in.learn_disable;
        qbit = spa_pkg::CPU_QUEUE_MASK_W'(1) << frame_in.action.cpu_queue_number;
        if (copy_hit) begin
            a_out.cpu_queue_mask = a_out.cpu_queue_mask | qbit;
        end
        if (once_hit) begin
            a_out.cpu_queue_mask = a_out.cpu_queue_mask | qbit;
        end
        if (frame_in.action.learn_disable) begin
            a_out.learn_disable = 1'b1;
        end
        if (pol_first) begin
            a_out.policer_valid = 1'b1;
            a_out.policer_index = frame_in.action.policer_index;
        end
        if (excl_first) begin
            a_out.exclusive_policing = 1'b1;
        end
        case (frame_in.action.mask_mode)
            spa_pkg::MASK_PERMIT: begin
                a_out.destination_set = s_destination_set & frame_in.action.port_mask;
            end
            spa_pkg::MASK_POLICY: begin
                a_out.destination_set = pol_destination_set;
            end
            spa_pkg::MASK_REDIRECT: begin
                a_out.destination_set = frame_in.action.port_mask;
            end
            default: begin
                a_out.destination_set = s_destination_set;
            end
        endcase
        a_out.mirror_enable = frame_in.action.mirror_flag;
        a_out.discarded = (a_out.destination_set == '0);
    end

    // ******************************************************
    // table read-back words
    // ******************************************************
    logic [31:0] prot_word;
    logic [31:0] svc_word;

    always_comb begin
        prot_word = '0;
        prot_word[spa_pkg::PROT_SCHEME_LSB +: 2] = prot_scheme_ff[tidx];
        prot_word[spa_pkg::PROT_GROUP_LSB +: spa_pkg::GRP_W] = prot_group_ff[tidx];
        prot_word[spa_pkg::PROT_PIDX_LSB +: spa_pkg::SVC_W] = prot_pidx_ff[tidx];
    end

    always_comb begin
        svc_word = '0;
        svc_word[spa_pkg::SVC_MASK_LSB +: spa_pkg::NUM_PORTS] = svc_mask_ff[tidx];
        svc_word[spa_pkg::SVC_FORCE_BIT] = svc_force_ff[tidx];
    end

    // ******************************************************
    // next state
    // ******************************************************
    always_comb begin
        nxt_state = state_ff;
        nxt_state.out_valid = frame_in_valid;
        if (frame_in_valid) begin
            nxt_state.out = a_out;
            nxt_state.frame_count = state_ff.frame_count + 32'h1;
            if (a_out.discarded) begin
                nxt_state.discard_count = state_ff.discard_count + 32'h1;
            end
        end
        if (setup_phase) begin
            nxt_state.rdata = '0;
            nxt_state.slverr = 1'b0;
            case (sel)
                spa_pkg::TBL_SEL_PROT: begin
                    nxt_state.rdata = prot_word;
                end
                spa_pkg::TBL_SEL_SVC: begin
                    nxt_state.rdata = svc_word;
                end
                spa_pkg::TBL_SEL_REG: begin
                    {nxt_state.slverr, nxt_state.rdata} = spa_scalar_rd(paddr, state_ff);
                end
                default: begin
                    nxt_state.slverr = 1'b1;
                end
            endcase
        end
        if (wr_access && (paddr == spa_pkg::ADDR_GROUP_PATH_STATE)) begin
            nxt_state.group_path_state = pwdata[spa_pkg::NUM_GROUPS-1:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_ff <= '0;
            state_ff.group_path_state <= spa_pkg::GROUP_PATH_STATE_RST;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ******************************************************
    // table writes
    // ******************************************************
    logic prot_wr;
    logic svc_wr;

    // a write lands at the access edge; the next frame already sees it
    assign prot_wr = wr_access && (sel == spa_pkg::TBL_SEL_PROT);
    assign svc_wr = wr_access && (sel == spa_pkg::TBL_SEL_SVC);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            for (int i = 0; i < spa_pkg::NUM_SERVICES; i++) begin
                prot_scheme_ff[i] <= spa_pkg::PROT_NONE;
                prot_group_ff[i] <= '0;
                prot_pidx_ff[i] <= '0;
                svc_force_ff[i] <= 1'b0;
                svc_mask_ff[i] <= spa_pkg::SVC_MASK_RST;
            end
        end else if (prot_wr) begin
            prot_scheme_ff[tidx] <= pwdata[spa_pkg::PROT_SCHEME_LSB +: 2];
            prot_group_ff[tidx] <= pwdata[spa_pkg::PROT_GROUP_LSB +: spa_pkg::GRP_W];
            prot_pidx_ff[tidx] <= pwdata[spa_pkg::PROT_PIDX_LSB +: spa_pkg::SVC_W];
        end else if (svc_wr) begin
            svc_mask_ff[tidx] <= pwdata[spa_pkg::SVC_MASK_LSB +: spa_pkg::NUM_PORTS];
            svc_force_ff[tidx] <= pwdata[spa_pkg::SVC_FORCE_BIT];
        end
    end

    // ******************************************************
    // outputs
    // ******************************************************
    // zero wait states: read data is captured in the setup cycle
    assign pready = 1'b1;
    assign prdata = state_ff.rdata;
    assign pslverr = state_ff.slverr;
    assign frame_out_valid = state_ff.out_valid;
    assign frame_out = state_ff.out;

endmodule : spa_stage

// [core/spa_pkg.sv]
package spa_pkg;

    // ******************************************************
    // sizes
    // ******************************************************
    localparam int NUM_SERVICES = 256;
    localparam int NUM_GROUPS = 23;
    localparam int NUM_PORTS = 11;
    localparam int SVC_W = 8;
    localparam int GRP_W = 5;
    localparam int CPU_QUEUE_MASK_W = 8;
    localparam int QNUM_W = 3;
    localparam int POL_W = 7;
    localparam int HIT_W = 32;
    localparam int ADDR_W = 12;

    // ******************************************************
    // register map (byte addresses)
    // ******************************************************
    localparam logic [11:0] ADDR_GROUP_PATH_STATE = 12'h000;
    localparam logic [11:0] ADDR_FRAME_COUNT = 12'h004;
    localparam logic [11:0] ADDR_DISCARD_COUNT = 12'h008;
    localparam logic [11:0] ADDR_PROT_BASE = 12'h400;
    localparam logic [11:0] ADDR_SVC_BASE = 12'h800;
    localparam logic [1:0] TBL_SEL_PROT = 2'h1;
    localparam logic [1:0] TBL_SEL_SVC = 2'h2;
    localparam logic [1:0] TBL_SEL_REG = 2'h0;
    localparam logic [1:0] TBL_SEL_NONE = 2'h3;
    localparam int TBL_SEL_LSB = 10;
    localparam int TBL_IDX_LSB = 2;

    // protection entry fields
    localparam int PROT_SCHEME_LSB = 0;
    localparam int PROT_GROUP_LSB = 8;
    localparam int PROT_PIDX_LSB = 16;
    // service entry fields
    localparam int SVC_MASK_LSB = 0;
    localparam int SVC_FORCE_BIT = 16;

    localparam logic [NUM_GROUPS-1:0] GROUP_PATH_STATE_RST = 23'h000000;
    localparam logic [NUM_PORTS-1:0] SVC_MASK_RST = 11'h7FF;

    // ******************************************************
    // enumerations
    // ******************************************************
    typedef enum logic [1:0] {
        PROT_NONE = 2'h0,
        PROT_UPSTREAM = 2'h1,
        PROT_DOWN_WORKING = 2'h2,
        PROT_DOWN_PROTECT = 2'h3
    } spa_scheme_t;

    typedef enum logic [1:0] {
        MASK_NONE = 2'h0,
        MASK_PERMIT = 2'h1,
        MASK_POLICY = 2'h2,
        MASK_REDIRECT = 2'h3
    } spa_mask_mode_t;

    // ******************************************************
    // carriers
    // ******************************************************
    typedef struct packed {
        logic cpu_copy_flag;
        logic [QNUM_W-1:0] cpu_queue_number;
        logic hit_once_flag;
        logic [HIT_W-1:0] rule_hit_counter;
        logic learn_disable;
        logic policer_select_flag;
        logic [POL_W-1:0] policer_index;
        logic exclusive_rule_policing;
        spa_mask_mode_t mask_mode;
        logic [NUM_PORTS-1:0] port_mask;
        logic mirror_flag;
    } spa_action_t;

    typedef struct packed {
        logic [SVC_W-1:0] service_index;
        logic [NUM_PORTS-1:0] destination_set;
        logic [NUM_PORTS-1:0] dmac_destination_set;
        logic [NUM_PORTS-1:0] vlan_mask;
        logic [NUM_PORTS-1:0] src_port_mask;
        logic [NUM_PORTS-1:0] aggr_mask;
        logic [CPU_QUEUE_MASK_W-1:0] cpu_queue_mask;
        logic learn_disable;
        logic first_lookup;
        spa_action_t action;
    } spa_frame_in_t;

    typedef struct packed {
        logic [SVC_W-1:0] service_index;
        logic [NUM_PORTS-1:0] destination_set;
        logic [CPU_QUEUE_MASK_W-1:0] cpu_queue_mask;
        logic learn_disable;
        logic policer_valid;
        logic [POL_W-1:0] policer_index;
        logic exclusive_policing;
        logic mirror_enable;
        logic discarded;
    } spa_frame_out_t;

endpackage : spa_pkg

// [tb/spa_peer.sv]
`timescale 1ns/1ps
module spa_peer (
    // clock
    input wire logic sys_clk,
    // frame to the stage
    output logic frame_in_valid,
    output spa_pkg::spa_frame_in_t frame_in,
    // result from the stage
    input wire logic frame_out_valid,
    input wire spa_pkg::spa_frame_out_t frame_out
);
    spa_pkg::spa_frame_out_t got_q[$];
    initial begin
        frame_in_valid = 1'b0;
        frame_in = '0;
    end
    // following stage has no back-pressure: every pulse is one result
    always @(posedge sys_clk) begin
        if (frame_out_valid === 1'b1) begin
            got_q.push_back(frame_out);
        end
    end
    task automatic send(input spa_pkg::spa_frame_in_t f);
        @(posedge sys_clk);
        frame_in_valid <= 1'b1;
        frame_in <= f;
    endtask : send
    // idle fields show the inverse so stale data never looks right
    task automatic idle();
        @(posedge sys_clk);
        frame_in_valid <= 1'b0;
        frame_in <= ~frame_in;
    endtask : idle
endmodule : spa_peer

// [tb/spa_stage_asserts.sv]
`timescale 1ns/1ps
module spa_chk (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // frame ports
    input wire logic frame_in_valid,
    input wire spa_pkg::spa_frame_in_t frame_in,
    input wire logic frame_out_valid,
    input wire spa_pkg::spa_frame_out_t frame_out
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence s_take(c);
        frame_in_valid && c;
    endsequence
    sequence s_res(c);
        frame_out_valid && c;
    endsequence
    res_pulse_a: assert property (s_take(1'b1) |=> s_res(1'b1))
        else $error("result pulse missing");
    no_stray_a: assert property (!frame_in_valid |=> !frame_out_valid)
        else $error("stray result pulse");
    cpu_copy_a: assert property (s_take(frame_in.action.cpu_copy_flag) |=>
        s_res(frame_out.cpu_queue_mask[$past(frame_in.action.cpu_queue_number)]))
        else $error("copy queue bit missing");
    keep_cpu_queue_mask_a: assert property (s_take(1'b1) |=> (frame_out.cpu_queue_mask &
        $past(frame_in.cpu_queue_mask)) == $past(frame_in.cpu_queue_mask))
        else $error("queue bits lost");
    learn_dis_a: assert property (s_take(frame_in.action.learn_disable) |=>
        s_res(frame_out.learn_disable)) else $error("learn flag missing");
    mirror_flag_a: assert property (s_take(1'b1) |=>
        frame_out.mirror_enable == $past(frame_in.action.mirror_flag))
        else $error("mirror flag wrong");
    later_pol_a: assert property (s_take(!frame_in.first_lookup) |=>
        !frame_out.policer_valid && !frame_out.exclusive_policing)
        else $error("policer on later lookup");
    redirect_a: assert property (s_take(frame_in.action.mask_mode == spa_pkg::MASK_REDIRECT)
        |=> frame_out.destination_set == $past(frame_in.action.port_mask))
        else $error("redirect set wrong");
    permit_a: assert property (s_take(frame_in.action.mask_mode == spa_pkg::MASK_PERMIT)
        |=> (frame_out.destination_set & ~$past(frame_in.action.port_mask)) == '0)
        else $error("permit leaked port");
    discard_a: assert property (frame_out_valid |->
        frame_out.discarded == (frame_out.destination_set == '0))
        else $error("discard flag wrong");
endmodule : spa_chk
bind spa_stage spa_chk chk_u (.sys_clk(sys_clk), .rst(rst),
    .frame_in_valid(frame_in_valid), .frame_in(frame_in),
    .frame_out_valid(frame_out_valid), .frame_out(frame_out));

// [tb/spa_stage_test.sv]
`timescale 1ns/1ps
module spa_stage_test;
    logic sys_clk, rst, psel, penable, pwrite, pready, pslverr, er;
    logic frame_in_valid, frame_out_valid;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [22:0] path_sh;
    logic [31:0] prot_sh [256];
    logic [31:0] svc_sh [256];
    spa_pkg::spa_frame_in_t frame_in;
    spa_pkg::spa_frame_out_t frame_out;
    spa_pkg::spa_frame_out_t exp_q[$];
    spa_pkg::spa_action_t a;
    int n_errors = 0, cmp_count = 0, n_frames = 0, n_disc = 0;
    spa_stage dut_u (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .frame_in_valid(frame_in_valid), .frame_in(frame_in),
        .frame_out_valid(frame_out_valid), .frame_out(frame_out));
    spa_peer peer_u (.sys_clk(sys_clk), .frame_in_valid(frame_in_valid), .frame_in(frame_in),
        .frame_out_valid(frame_out_valid), .frame_out(frame_out));
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    // ********************************
    // helpers
    // ********************************
    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (w && ad == 12'h000) path_sh = d[22:0];
        if (w && ad[11:10] == spa_pkg::TBL_SEL_PROT) prot_sh[ad[9:2]] = d;
        if (w && ad[11:10] == spa_pkg::TBL_SEL_SVC) svc_sh[ad[9:2]] = d;
    endtask : apb
    function automatic spa_pkg::spa_frame_out_t model(spa_pkg::spa_frame_in_t f);
        spa_pkg::spa_frame_out_t o;
        spa_pkg::spa_action_t c;
        logic [31:0] p, s;
        logic pr, kill;
        logic [10:0] filt, d;
        c = f.action;
        p = prot_sh[f.service_index];
        // groups past the last one read as working
        pr = p[12:8] < 5'h17 && path_sh[p[12:8]];
        o = '0;
        o.service_index = (p[1:0] == 2'h1 && pr) ? p[23:16] : f.service_index;
        kill = p[1] && (p[0] ^ pr);
        s = svc_sh[o.service_index];
        filt = f.src_port_mask & f.aggr_mask;
        d = kill ? '0 : s[16] ? s[10:0] & filt : f.destination_set & s[10:0];
        case (c.mask_mode)
            spa_pkg::MASK_PERMIT: d = d & c.port_mask;
            spa_pkg::MASK_POLICY: d = kill ? '0 : s[16] ? s[10:0] & filt
                : c.port_mask & f.vlan_mask & filt & s[10:0];
            spa_pkg::MASK_REDIRECT: d = c.port_mask;
            default: ;
        endcase
        o.destination_set = d;
        o.cpu_queue_mask = f.cpu_queue_mask;
        if (c.cpu_copy_flag || (c.hit_once_flag && c.rule_hit_counter == 0)) begin
            o.cpu_queue_mask[c.cpu_queue_number] = 1'b1;
        end
        o.learn_disable = f.learn_disable | c.learn_disable;
        o.policer_valid = f.first_lookup & c.policer_select_flag;
        o.policer_index = o.policer_valid ? c.policer_index : '0;
        o.exclusive_policing = f.first_lookup & c.exclusive_rule_policing;
        o.mirror_enable = c.mirror_flag;
        o.discarded = d == '0;
        return o;
    endfunction : model
    task automatic frame(input logic [7:0] svc, input logic [10:0] dst, input logic first);
        spa_pkg::spa_frame_in_t f;
        f = {svc, dst, 11'h5A5, 11'h7F3, 11'h6FF, 11'h7BF, 8'h10, 1'b0, first, a};
        exp_q.push_back(model(f));
        n_frames++;
        n_disc += int'(exp_q[$].discarded);
        peer_u.send(f);
    endtask : frame
    task automatic flush();
        spa_pkg::spa_frame_out_t g, e;
        peer_u.idle();
        repeat (3) @(posedge sys_clk);
        chk(64'(peer_u.got_q.size()), 64'(exp_q.size()), "result count");
        while (exp_q.size() > 0 && peer_u.got_q.size() > 0) begin
            e = exp_q.pop_front();
            g = peer_u.got_q.pop_front();
            chk(64'(g), 64'(e), "frame result");
        end
        exp_q.delete();
        peer_u.got_q.delete();
    endtask : flush
    // ********************************
    // scenarios
    // ********************************
    task automatic t_regs();
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h0, "path reset");
        apb(1'b0, 12'h7FC, 32'h0);
        chk(rd, 32'h0, "prot reset");
        apb(1'b0, 12'h804, 32'h0);
        chk(rd, 32'h7FF, "svc reset");
        apb(1'b1, 12'h004, 32'h1234);
        chk(er, 1'b0, "ro write");
        apb(1'b0, 12'h00C, 32'h0);
        chk({er, rd}, {1'b1, 32'h0}, "unmapped");
    endtask : t_regs
    task automatic t_prot();
        a = '0;
        apb(1'b1, 12'h824, 32'h0F0);
        for (int sc = 0; sc < 4; sc++) begin
            for (int st = 0; st < 2; st++) begin
                apb(1'b1, 12'h414, {8'h0, 8'h09, 3'h0, 5'h16, 6'h0, 2'(sc)});
                apb(1'b1, 12'h418, {8'h0, 8'h0A, 3'h0, 5'h16, 6'h0, 2'h1});
                apb(1'b1, 12'h41C, {8'h0, 8'h0B, 3'h0, 5'h17, 6'h0, 2'(sc)});
                apb(1'b1, 12'h000, {9'h0, st[0], 22'h0});
                frame(8'h05, 11'h3FF, 1'b1);
                frame(8'h06, 11'h3FF, 1'b1);
                frame(8'h07, 11'h3FF, 1'b1);
                flush();
            end
        end
        apb(1'b1, 12'h000, 32'h0);
        // forced result still filtered by source and aggregation masks
        apb(1'b1, 12'h830, 32'h103C5);
        apb(1'b1, 12'h834, 32'h3C5);
        frame(8'h0C, 11'h00F, 1'b1);
        frame(8'h0D, 11'h00F, 1'b1);
        frame(8'h0C, 11'h000, 1'b1);
        flush();
    endtask : t_prot
    task automatic t_act();
        for (int m = 0; m < 4; m++) begin
            a = '0;
            a.mask_mode = spa_pkg::spa_mask_mode_t'(m);
            a.port_mask = 11'h1E3;
            a.cpu_copy_flag = m[0];
            a.cpu_queue_number = 3'(m + 2);
            a.hit_once_flag = 1'b1;
            a.rule_hit_counter = {31'h0, m[1]};
            a.learn_disable = m[1];
            a.policer_select_flag = 1'b1;
            a.policer_index = 7'(m * 9 + 1);
            a.exclusive_rule_policing = !m[0];
            a.mirror_flag = m[0];
            frame(8'h0D, 11'h7FE, m[0] ^ m[1]);
            frame(8'h05, 11'h7FE, 1'b1);
            frame(8'h0C, 11'h7FE, 1'b1);
        end
        flush();
    endtask : t_act
    task automatic finish_test();
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test
    initial begin
        rst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        path_sh = '0;
        for (int i = 0; i < 256; i++) begin
            prot_sh[i] = 32'h0;
            svc_sh[i] = 32'h7FF;
        end
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        t_regs();
        t_prot();
        t_act();
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'(n_frames), "frame count");
        apb(1'b0, 12'h008, 32'h0);
        chk(rd, 32'(n_disc), "discard count");
        finish_test();
    end
    initial begin
        #500000;
        n_errors++;
        finish_test();
    end
endmodule : spa_stage_test
